// ---- core/dsq_status_query.sv ----
// Device status query register: selector write, 64-bit snapshot, byte-wise read-back.
`timescale 1ns/100ps
`default_nettype none
`include "dsq_defs.svh"
module dsq_status_query
  import dsq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Host write port: a one-cycle strobe with register address and one data byte.
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Host read port: each strobe in the SEND state, outside the cycle of a query write, pops one response byte.
  input  wire logic       rd_stb,
  output var  logic [7:0] rd_data,
  output var  logic       rd_valid,
  output var  logic       resp_pending,
  // Configuration levels from the device's own register logic.
  input  wire logic       trig_out_per_cycle,
  input  wire logic       trig_out_enable,
  input  wire logic       return_to_start,
  input  wire logic       hw_trig_steps,
  input  wire logic       hw_trig_source,
  input  wire logic       sweep_sawtooth,
  input  wire logic       sweep_reverse,
  input  wire logic       manual_points,
  input  wire logic       sweep_on_power_up,
  input  wire logic       backplane_clk_out,
  input  wire logic       spur_suppress,
  input  wire logic       list_mode_select,
  input  wire logic       list_running,
  input  wire logic       ref_out_100m,
  input  wire logic       ext_lock_enable,
  input  wire logic       rf_output_enable,
  input  wire logic       auto_level_disable,
  input  wire logic       standby_enable,
  input  wire logic       low_loop_gain,
  input  wire logic       fractional_lock,
  input  wire logic       ref_in_100m,
  input  wire logic       direct_ref_clocking,
  // Asynchronous pin levels: sensors and loop lock detectors.
  input  wire logic       over_temp_pin,
  input  wire logic       ext_ref_detect_pin,
  input  wire logic       oven_oscillator_lock,
  input  wire logic       crystal_vco_lock,
  input  wire logic       coarse_aux_lock,
  input  wire logic       coarse_ref_lock,
  input  wire logic       fine_loop_lock,
  input  wire logic       coarse_loop_lock,
  input  wire logic       main_loop_lock,
  input  wire logic       backplane_clk_pin
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [9:0] pins_async;
  logic [9:0] pins;

  assign pins_async[9] = over_temp_pin;
  assign pins_async[8] = ext_ref_detect_pin;
  assign pins_async[7] = oven_oscillator_lock;
  assign pins_async[6] = crystal_vco_lock;
  assign pins_async[5] = coarse_aux_lock;
  assign pins_async[4] = coarse_ref_lock;
  assign pins_async[3] = fine_loop_lock;
  assign pins_async[2] = coarse_loop_lock;
  assign pins_async[1] = main_loop_lock;
  assign pins_async[0] = backplane_clk_pin;

  dsq_sync #(
    .W        (10)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (pins_async),
    .sync_out (pins)
  );

  logic over_temp_s;
  logic ext_ref_det_s;
  logic oven_lock_s;
  logic vco_lock_s;
  logic aux_lock_s;
  logic cref_lock_s;
  logic fine_lock_s;
  logic crs_lock_s;
  logic main_lock_s;
  logic bp_clk_s;

  assign over_temp_s   = pins[9];
  assign ext_ref_det_s = pins[8];
  assign oven_lock_s   = pins[7];
  assign vco_lock_s    = pins[6];
  assign aux_lock_s    = pins[5];
  assign cref_lock_s   = pins[4];
  assign fine_lock_s   = pins[3];
  assign crs_lock_s    = pins[2];
  assign main_lock_s   = pins[1];
  assign bp_clk_s      = pins[0];

  // ****************************************************************
  // Query decode
  // ****************************************************************
  logic query_wr;
  logic refcfg_sel;

  assign query_wr = wr_stb && (wr_addr == `DSQ_REG_ADDR);
  // Only bit 0 of the selector is meaningful; upper bits are ignored.
  assign refcfg_sel = (wr_data[0] == `DSQ_SEL_REFCFG);

  // Device accessed flag: set by the first query write, held until reset.
  logic accessed;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      accessed <= 1'b0;
    else if (query_wr)
      accessed <= 1'b1;
  end

  // ****************************************************************
  // Snapshot assembly
  // ****************************************************************
  logic [63:0] next_snapshot;
  logic [7:0]  list_cfg_byte;
  logic [7:0]  operate_hi_byte;
  logic [7:0]  operate_lo_byte;
  logic [7:0]  low_byte;

  // List configuration flags, answer bits 31 down to 24.
  always_comb
  begin
    list_cfg_byte    = 8'h00;
    list_cfg_byte[7] = trig_out_per_cycle;
    list_cfg_byte[6] = trig_out_enable;
    list_cfg_byte[5] = return_to_start;
    list_cfg_byte[4] = hw_trig_steps;
    list_cfg_byte[3] = hw_trig_source;
    list_cfg_byte[2] = sweep_sawtooth;
    list_cfg_byte[1] = sweep_reverse;
    list_cfg_byte[0] = manual_points;
  end

  // Operating flags, answer bits 23 down to 16; bit 23 carries nothing and stays low.
  always_comb
  begin
    operate_hi_byte    = 8'h00;
    operate_hi_byte[6] = sweep_on_power_up;
    operate_hi_byte[5] = backplane_clk_out;
    operate_hi_byte[4] = spur_suppress;
    operate_hi_byte[3] = over_temp_s;
    operate_hi_byte[2] = list_mode_select;
    operate_hi_byte[1] = list_running;
    operate_hi_byte[0] = ref_out_100m;
  end

  // Operating flags, answer bits 15 down to 8.
  always_comb
  begin
    operate_lo_byte    = 8'h00;
    operate_lo_byte[7] = ext_ref_det_s;
    operate_lo_byte[6] = ext_lock_enable;
    operate_lo_byte[5] = rf_output_enable;
    operate_lo_byte[4] = auto_level_disable;
    operate_lo_byte[3] = standby_enable;
    // The query itself counts as an access, so the flag reads set in its own answer.
    operate_lo_byte[2] = 1'b1;
    operate_lo_byte[1] = low_loop_gain;
    operate_lo_byte[0] = fractional_lock;
  end

  // Loop lock flags, or the reference configuration view; bit 7 carries nothing.
  always_comb
  begin
    low_byte    = 8'h00;
    low_byte[6] = oven_lock_s;
    low_byte[5] = vco_lock_s;
    case (refcfg_sel)
      1'b1:
      begin
        low_byte[4] = ref_in_100m;
        low_byte[3] = direct_ref_clocking;
        low_byte[2] = bp_clk_s;
        low_byte[1] = ref_out_100m;
        low_byte[0] = ext_lock_enable;
      end
      default:
      begin
        low_byte[4] = aux_lock_s;
        low_byte[3] = cref_lock_s;
        low_byte[2] = fine_lock_s;
        low_byte[1] = crs_lock_s;
        low_byte[0] = main_lock_s;
      end
    endcase
  end

  // The upper half carries no data and always reads as zeros.
  assign next_snapshot = {32'h0000_0000, list_cfg_byte, operate_hi_byte,
                          operate_lo_byte, low_byte};

  // ****************************************************************
  // Read-back buffer and byte sequencer
  // ****************************************************************
  dsq_state_t  state;
  logic [63:0] rb_buf;
  logic [3:0]  byte_cnt;

  // A new query always restarts the buffer; a host that skips bytes loses them.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= DSQ_IDLE;
    else
    begin
      case (state)
        DSQ_IDLE:
          if (query_wr)
            state <= DSQ_LOAD;
        DSQ_LOAD:
          state <= DSQ_SEND;
        DSQ_SEND:
          if (query_wr)
            state <= DSQ_LOAD;
          else if (rd_stb && (byte_cnt == `DSQ_BYTE_LAST))
            state <= DSQ_IDLE;
        default:
          state <= DSQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rb_buf <= 64'h0000_0000_0000_0000;
    else if (query_wr)
      rb_buf <= next_snapshot;
    else if ((state == DSQ_SEND) && rd_stb)
      rb_buf <= {rb_buf[55:0], 8'h00};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      byte_cnt <= 4'h0;
    else if (query_wr)
      byte_cnt <= 4'h0;
    else if ((state == DSQ_SEND) && rd_stb)
      byte_cnt <= byte_cnt + 4'h1;
  end

  // A read is taken only in SEND and never in the cycle of a new query, which wins.
  logic rd_take;
  logic rd_last;

  assign rd_take = (state == DSQ_SEND) && rd_stb && !query_wr;
  assign rd_last = rd_take && (byte_cnt == `DSQ_BYTE_LAST);

  // Most significant byte leaves first; read data is registered one cycle after the strobe.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_valid <= 1'b0;
    else
      rd_valid <= rd_take;
  end

  // Outside a read the data lines rest at zero, so a stale byte is never seen.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 8'h00;
    else if (rd_take)
      rd_data <= rb_buf[63:56];
    else
      rd_data <= 8'h00;
  end

  // Pending rises with the query itself, so the host sees it in the very next cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      resp_pending <= 1'b0;
    else
      resp_pending <= query_wr || (state == DSQ_LOAD) ||
                      ((state == DSQ_SEND) && !rd_last);
  end

endmodule : dsq_status_query
`default_nettype wire

// ---- pkg/dsq_defs.svh ----
// Constants for the device status query block: address, selector codes, byte counts, synchroniser depth.
`ifndef DSQ_DEFS_SVH
`define DSQ_DEFS_SVH
`define DSQ_REG_ADDR      8'h22
`define DSQ_SEL_STATUS    8'h00
`define DSQ_SEL_REFCFG    8'h01
`define DSQ_RESP_BYTES    4'h8
`define DSQ_BYTE_LAST     4'h7
`define DSQ_SYNC_STAGES   3
`endif

// ---- pkg/dsq_pkg.sv ----
// Types shared by the device status query block.
package dsq_pkg;
  typedef enum logic [1:0] {
    DSQ_IDLE  = 2'b00,
    DSQ_LOAD  = 2'b01,
    DSQ_SEND  = 2'b11
  } dsq_state_t;
endpackage : dsq_pkg

// ---- core/dsq_sync.sv ----
// Three-stage synchroniser with second/third agreement filter for a bus of pin levels.
`timescale 1ns/100ps
`default_nettype none
module dsq_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit changes only once the last two stages agree, so a single-cycle glitch is dropped.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_out <= '0;
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (stage2[i] == stage3[i])
          sync_out[i] <= stage3[i];
      end
    end
  end
endmodule : dsq_sync
`default_nettype wire

// ---- testbench/dsq_query_props.sv ----
// Port checker for the status query register.
`timescale 1ns/100ps
`default_nettype none
`include "dsq_defs.svh"
module dsq_query_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       wr_stb,
  input wire logic [7:0] wr_addr,
  input wire logic       rd_stb,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic       resp_pending
);
  // ****
  // Byte position of the answer.
  // ****
  logic [3:0] byte_idx;
  wire logic  query = wr_stb && (wr_addr == `DSQ_REG_ADDR);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      byte_idx <= 4'h0;
    else if (query)
      byte_idx <= 4'h0;
    else if (rd_valid)
      byte_idx <= byte_idx + 4'h1;
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_query; wr_stb && wr_addr == `DSQ_REG_ADDR; endsequence
  sequence s_in_send; resp_pending && $past(resp_pending) && !$past(query); endsequence
  property p_pend_after_query; s_query |=> resp_pending; endproperty
  property p_pend_cause; $rose(resp_pending) |-> $past(query); endproperty
  property p_read_answer; (rd_stb && !query) ##0 s_in_send |=> rd_valid; endproperty
  property p_valid_cause; rd_valid |-> $past(rd_stb); endproperty
  property p_idle_refuse; !resp_pending && rd_stb |=> !rd_valid; endproperty
  property p_upper_zero; rd_valid && byte_idx < 4'h4 |-> rd_data == 8'h00; endproperty
  property p_gap_zero; rd_valid && (byte_idx == 4'h5 || byte_idx == 4'h7) |-> !rd_data[7]; endproperty
  property p_accessed; rd_valid && byte_idx == 4'h6 |-> rd_data[2]; endproperty
  property p_eight_bytes; $fell(resp_pending) |-> rd_valid && byte_idx == 4'h7; endproperty
  a_pend_after_query: assert property (p_pend_after_query) else $error("no pending");
  a_pend_cause: assert property (p_pend_cause) else $error("pending without query");
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  a_valid_cause: assert property (p_valid_cause) else $error("valid without read");
  a_idle_refuse: assert property (p_idle_refuse) else $error("idle read answered");
  a_upper_zero: assert property (p_upper_zero) else $error("upper half not zero");
  a_gap_zero: assert property (p_gap_zero) else $error("unused bit set");
  a_accessed: assert property (p_accessed) else $error("accessed flag clear");
  a_eight_bytes: assert property (p_eight_bytes) else $error("byte count wrong");
endmodule : dsq_query_props
bind dsq_status_query dsq_query_props chk_u (.clk(clk), .rst_n(rst_n), .wr_stb(wr_stb),
  .wr_addr(wr_addr), .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid),
  .resp_pending(resp_pending));
`default_nettype wire

// ---- testbench/dsq_host.sv ----
// Host model that writes queries and reads back the answer bytes.
`timescale 1ns/100ps
`default_nettype none
module dsq_host (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output var  logic       wr_stb,
  output var  logic [7:0] wr_addr,
  output var  logic [7:0] wr_data,
  output var  logic       rd_stb
);
  // ****
  // Bus cycles.
  // ****
  logic [63:0] got = 64'h0;
  int          nbytes = 0;
  initial {wr_stb, wr_addr, wr_data, rd_stb} = 18'h0;
  always @(negedge clk)
  begin
    if (rd_valid === 1'b1)
    begin
      got = {got[55:0], rd_data};
      nbytes++;
    end
  end
  task automatic query(input logic [7:0] addr, input logic [7:0] sel);
    @(negedge clk);
    {wr_stb, wr_addr, wr_data} = {1'b1, addr, sel};
    @(negedge clk);
    // Released lines carry the inverse so a stale value cannot pass for a good one.
    {wr_stb, wr_addr, wr_data} = {1'b0, ~addr, ~sel};
    @(negedge clk);
  endtask : query
  task automatic read_all(input int gap, output logic [63:0] w, output int n);
    int n0;
    n0 = nbytes;
    for (int i = 0; i < 8; i++)
    begin
      rd_stb = 1'b1;
      @(negedge clk);
      if (gap > 0)
      begin
        rd_stb = 1'b0;
        repeat (gap) @(negedge clk);
      end
    end
    rd_stb = 1'b0;
    repeat (2) @(negedge clk);
    w = got;
    n = nbytes - n0;
  endtask : read_all
endmodule : dsq_host
`default_nettype wire

// ---- testbench/dsq_status_query_bench.sv ----
// Self-checking bench for the device status query register.
`timescale 1ns/100ps
`default_nettype none
module dsq_status_query_bench;
  // ****
  // Harness.
  // ****
  logic        clk = 1'b0;
  logic        rst_n, wr_stb, rd_stb, rd_valid, resp_pending;
  logic [21:0] c;
  logic [9:0]  p;
  logic [7:0]  wr_addr, wr_data, rd_data;
  logic [63:0] w;
  int          n, seed, cycles, miscompares, compares;
  always #25 clk = ~clk;
  dsq_host host_u (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_stb(rd_stb));
  dsq_status_query dut_u (.clk(clk), .rst_n(rst_n), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid),
    .resp_pending(resp_pending), .trig_out_per_cycle(c[21]), .trig_out_enable(c[20]),
    .return_to_start(c[19]), .hw_trig_steps(c[18]), .hw_trig_source(c[17]),
    .sweep_sawtooth(c[16]), .sweep_reverse(c[15]), .manual_points(c[14]),
    .sweep_on_power_up(c[13]), .backplane_clk_out(c[12]), .spur_suppress(c[11]),
    .list_mode_select(c[10]), .list_running(c[9]), .ref_out_100m(c[8]),
    .ext_lock_enable(c[7]), .rf_output_enable(c[6]), .auto_level_disable(c[5]),
    .standby_enable(c[4]), .low_loop_gain(c[3]), .fractional_lock(c[2]), .ref_in_100m(c[1]),
    .direct_ref_clocking(c[0]), .over_temp_pin(p[9]), .ext_ref_detect_pin(p[8]),
    .oven_oscillator_lock(p[7]), .crystal_vco_lock(p[6]), .backplane_clk_pin(p[5]),
    .coarse_aux_lock(p[4]), .coarse_ref_lock(p[3]), .fine_loop_lock(p[2]),
    .coarse_loop_lock(p[1]), .main_loop_lock(p[0]));
  function automatic logic [63:0] expect_word(input logic sel, input logic [21:0] cf,
                                              input logic [9:0] pn);
    logic [63:0] r;
    r = {32'h0, cf[21:14], 1'b0, cf[13:11], pn[9], cf[10:8], pn[8], cf[7:4], 1'b1, cf[3:2],
         1'b0, pn[7:6], pn[4:0]};
    if (sel)
      r[4:0] = {cf[1], cf[0], pn[5], cf[8], cf[7]};
    return r;
  endfunction : expect_word
  task automatic cmp_word(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word
  task automatic tally_and_finish;
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic run_one(input logic [7:0] addr, input logic [7:0] sel, input int gap);
    host_u.query(addr, sel);
    host_u.read_all(gap, w, n);
    if (addr == 8'h22)
    begin
      cmp_word("word", expect_word(sel[0], c, p), w);
      cmp_word("count", 64'h8, 64'(n));
    end
    else
      cmp_word("count", 64'h0, 64'(n));
    cmp_word("pending", 64'h0, {63'h0, resp_pending});
    host_u.read_all(0, w, n);
    cmp_word("extra", 64'h0, 64'(n));
  endtask : run_one
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    seed = 32'h484a59f3;
    {c, p, rst_n, cycles, miscompares, compares} = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    // The first two passes set every flag low and then high.
    for (int i = 0; i < 24; i++)
    begin
      c = (i == 0) ? 22'h0 : (i == 1) ? 22'h3fffff : 22'($random(seed));
      p = (i == 0) ? 10'h0 : (i == 1) ? 10'h3ff : 10'($random(seed));
      repeat (8) @(negedge clk);
      run_one((i == 2) ? 8'h23 : 8'h22, {7'($random(seed)), i[0]}, i % 3);
    end
    tally_and_finish();
  end
endmodule : dsq_status_query_bench
`default_nettype wire
